// file: shared/fbw_pkg.sv
package fbw_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int AXI_AW   = 8;
  localparam int ADDR_W   = 16;
  localparam int TMR_W    = 16;
  localparam int LANES    = 4;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CACHE_CTRL  = 8'h00;
  localparam logic [7:0] OFS_BANK        = 8'h04;
  localparam logic [7:0] OFS_PS_CTRL     = 8'h08;
  localparam logic [7:0] OFS_FLASH_SCALE = 8'h0C;
  localparam logic [7:0] OFS_STATUS      = 8'h10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_BLK_SEL = 0;
  localparam int BANK_LSB    = 4;
  localparam int BANK_MSB    = 5;
  localparam int BIT_REDIR   = 0;
  localparam int BIT_SCRATCH = 2;
  localparam int BIT_WRERASE = 0;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_MASK   = 4;
  localparam int STAT_COUNT  = 16;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic       RST_BLK_SEL = 1'b0;
  localparam logic [1:0] RST_BANK    = 2'h0;
  localparam logic       RST_REDIR   = 1'b0;
  localparam logic       RST_SCRATCH = 1'b0;
  localparam logic       RST_WRERASE = 1'b0;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ****************************************
  // AXI responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ     = 200;
  localparam int PGM_TIME_NS = 20000;
  // Least time: round up
  localparam int PGM_CYCLES  = (PGM_TIME_NS * CLK_MHZ + 999) / 1000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [0:0] {
    FBW_IDLE = 1'b0,
    FBW_PROG = 1'b1
  } fbw_fsm_e;

  typedef struct packed {
    fbw_fsm_e              fsm;
    logic [TMR_W-1:0]      timer;
    logic                  blkSel;
    logic [1:0]            bank;
    logic                  redirEn;
    logic                  scratchEn;
    logic                  wrEraseEn;
    logic [31:0]           bufData;
    logic [LANES-1:0]      bufMask;
    logic                  moveReady;
    logic                  pgmStart;
    logic [ADDR_W-1:0]     pgmAddr;
    logic [31:0]           pgmData;
    logic [LANES-1:0]      pgmByteEn;
    logic [1:0]            pgmBank;
    logic                  pgmScratch;
    logic [15:0]           pgmCount;
    logic                  extRamWrEn;
    logic [ADDR_W-1:0]     extRamWrAddr;
    logic [7:0]            extRamWrData;
    logic                  awready;
    logic                  wready;
    logic                  awHeld;
    logic                  wHeld;
    logic [AXI_AW-1:0]     awAddr;
    logic [31:0]           wData;
    logic [3:0]            wStrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } fbw_state_s;

endpackage

// file: rtl/fbw_flash_block_writer.sv
// Contract
// RULE1: Single mode programs after every move write
// RULE2: Block mode: four bytes code, two scratchpad
// RULE3: Block program time equals single byte time
// RULE4: Block mode holds program until last byte
// RULE5: Software writes code block bytes ascending
// RULE6: Code block starts after address ending 11b
// RULE7: Scratchpad block starts after address ending 1b
// RULE8: Unwanted block bytes are written as FF
// RULE9: Write/erase enable gates all programming
// RULE10: Store write enable steers moves to flash
// RULE11: Scratchpad enable targets scratchpad area
// RULE12: Bank field picks bank for writes
// RULE13: Software follows enable and disable sequence
// RULE14: Block select is bit 0, read/write
// RULE15: No programming unless both enables set
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module fbw_flash_block_writer
  import fbw_pkg::*;
#(
  parameter int PGM_CYC = PGM_CYCLES
) (
  // Clock, reset, enable
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              ce,
  // AXI4-Lite write address
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Move writes from the core
  input  wire logic              moveWrValid,
  input  wire logic [ADDR_W-1:0] moveWrAddr,
  input  wire logic [7:0]        moveWrData,
  output logic                   moveWrReady,
  // Flash programming command
  output logic                   flashPgmStart,
  output logic [ADDR_W-1:0]      flashPgmAddr,
  output logic [31:0]            flashPgmData,
  output logic [LANES-1:0]       flashPgmByteEn,
  output logic [1:0]             flashPgmBank,
  output logic                   flashPgmScratch,
  // External data RAM write
  output logic                   extRamWrEn,
  output logic [ADDR_W-1:0]      extRamWrAddr,
  output logic [7:0]             extRamWrData
);

  // ****************************************
  // State
  // ****************************************
  fbw_state_s        s;
  fbw_state_s        s_nxt;
  logic              moveTake;
  logic [1:0]        lane;
  logic              lastByte;
  logic [31:0]       blkData;
  logic [31:0]       oneData;
  logic [LANES-1:0]  oneEn;
  logic [31:0]       rdMux;
  logic [1:0]        rdResp;

  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(PGM_CYC - 1);

  assign moveTake = moveWrValid && s.moveReady;
  assign lane     = moveWrAddr[1:0];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt    = s;
    lastByte = 1'b0;
    blkData  = s.bufData;
    oneData  = {LANES{ERASED_BYTE}};
    oneEn    = '0;
    rdMux    = 32'h0000_0000;
    rdResp   = RESP_OKAY;
    s_nxt.pgmStart = 1'b0;
    s_nxt.extRamWrEn = 1'b0;

    // Lane placement of the incoming byte
    for (int i = 0; i < LANES; i++) begin
      if (lane == 2'(i)) begin
        blkData[i*8 +: 8] = moveWrData;
        oneData[i*8 +: 8] = moveWrData;
        oneEn[i]          = 1'b1;
      end
    end

    // Scratchpad blocks pair on address bit 0, code blocks on 1:0
    if (s.scratchEn) begin
      lastByte = moveWrAddr[0]; // RULE7 RULE2
    end else begin
      lastByte = (moveWrAddr[1:0] == 2'b11); // RULE6 RULE2
    end

    // Programming timer; same length for single and block
    if (s.fsm == FBW_PROG) begin
      if (s.timer == TMR_LAST) begin // RULE3
        s_nxt.fsm   = FBW_IDLE;
        s_nxt.timer = '0;
      end else begin
        s_nxt.timer = s.timer + TMR_W'(1);
      end
    end

    if (moveTake) begin
      if (!s.redirEn) begin
        // Redirect off: plain data RAM write
        s_nxt.extRamWrEn   = 1'b1; // RULE10
        s_nxt.extRamWrAddr = moveWrAddr;
        s_nxt.extRamWrData = moveWrData;
      end else if (s.wrEraseEn) begin // RULE9 RULE15
        s_nxt.pgmBank    = s.bank; // RULE12
        s_nxt.pgmScratch = s.scratchEn; // RULE11
        if (!s.blkSel) begin
          s_nxt.pgmStart  = 1'b1; // RULE1
          s_nxt.pgmAddr   = moveWrAddr;
          s_nxt.pgmData   = oneData;
          s_nxt.pgmByteEn = oneEn;
          s_nxt.fsm       = FBW_PROG;
          s_nxt.timer     = '0;
          s_nxt.pgmCount  = s.pgmCount + 16'h0001;
        end else if (!lastByte) begin
          // Hold in buffer until the top byte arrives
          s_nxt.bufData = blkData; // RULE4
          s_nxt.bufMask = s.bufMask | oneEn;
        end else begin
          s_nxt.pgmStart = 1'b1; // RULE6 RULE7
          s_nxt.pgmData  = blkData;
          s_nxt.fsm      = FBW_PROG;
          s_nxt.timer    = '0;
          s_nxt.pgmCount = s.pgmCount + 16'h0001;
          if (s.scratchEn) begin
            s_nxt.pgmAddr   = {moveWrAddr[ADDR_W-1:1], 1'b0};
            s_nxt.pgmByteEn = moveWrAddr[1] ? 4'hC : 4'h3;
          end else begin
            s_nxt.pgmAddr   = {moveWrAddr[ADDR_W-1:2], 2'b00};
            s_nxt.pgmByteEn = 4'hF;
          end
          // Unwritten lanes leave the flash as erased
          s_nxt.bufData = {LANES{ERASED_BYTE}}; // RULE8
          s_nxt.bufMask = '0;
        end
      end
      // Write/erase enable clear with redirect set: write is dropped
    end

    // No new move write while programming runs
    s_nxt.moveReady = (s_nxt.fsm == FBW_IDLE);

    // ****************************************
    // AXI write channel
    // ****************************************
    if (s_axi_awvalid && s.awready) begin
      s_nxt.awHeld  = 1'b1;
      s_nxt.awAddr  = s_axi_awaddr;
      s_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && s.wready) begin
      s_nxt.wHeld  = 1'b1;
      s_nxt.wData  = s_axi_wdata;
      s_nxt.wStrb  = s_axi_wstrb;
      s_nxt.wready = 1'b0;
    end
    if (s.awHeld && s.wHeld && !s.bvalid) begin
      s_nxt.awHeld = 1'b0;
      s_nxt.wHeld  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = RESP_OKAY;
      if (s.awAddr[AXI_AW-1:2] == OFS_CACHE_CTRL[AXI_AW-1:2]) begin
        if (s.wStrb[0]) begin
          s_nxt.blkSel = s.wData[BIT_BLK_SEL]; // RULE14
        end
      end else if (s.awAddr[AXI_AW-1:2] == OFS_BANK[AXI_AW-1:2]) begin
        if (s.wStrb[0]) begin
          s_nxt.bank = s.wData[BANK_MSB:BANK_LSB]; // RULE12
        end
      end else if (s.awAddr[AXI_AW-1:2] == OFS_PS_CTRL[AXI_AW-1:2]) begin
        if (s.wStrb[0]) begin
          s_nxt.redirEn   = s.wData[BIT_REDIR]; // RULE10
          s_nxt.scratchEn = s.wData[BIT_SCRATCH]; // RULE11
        end
      end else if (s.awAddr[AXI_AW-1:2] ==
                   OFS_FLASH_SCALE[AXI_AW-1:2]) begin
        if (s.wStrb[0]) begin
          s_nxt.wrEraseEn = s.wData[BIT_WRERASE]; // RULE9
        end
      end else if (s.awAddr[AXI_AW-1:2] == OFS_STATUS[AXI_AW-1:2]) begin
        s_nxt.bresp = RESP_OKAY;
      end else begin
        s_nxt.bresp = RESP_SLVERR;
      end
    end
    if (s.bvalid && s_axi_bready) begin
      s_nxt.bvalid  = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready  = 1'b1;
    end

    // ****************************************
    // AXI read channel
    // ****************************************
    if (s_axi_araddr[AXI_AW-1:2] == OFS_CACHE_CTRL[AXI_AW-1:2]) begin
      rdMux[BIT_BLK_SEL] = s.blkSel; // RULE14
    end else if (s_axi_araddr[AXI_AW-1:2] == OFS_BANK[AXI_AW-1:2]) begin
      rdMux[BANK_MSB:BANK_LSB] = s.bank;
    end else if (s_axi_araddr[AXI_AW-1:2] == OFS_PS_CTRL[AXI_AW-1:2]) begin
      rdMux[BIT_REDIR]   = s.redirEn;
      rdMux[BIT_SCRATCH] = s.scratchEn;
    end else if (s_axi_araddr[AXI_AW-1:2] ==
                 OFS_FLASH_SCALE[AXI_AW-1:2]) begin
      rdMux[BIT_WRERASE] = s.wrEraseEn;
    end else if (s_axi_araddr[AXI_AW-1:2] == OFS_STATUS[AXI_AW-1:2]) begin
      rdMux[STAT_BUSY]                   = (s.fsm == FBW_PROG);
      rdMux[STAT_MASK +: LANES]          = s.bufMask;
      rdMux[STAT_COUNT +: 16]            = s.pgmCount;
    end else begin
      rdResp = RESP_SLVERR;
    end
    if (s_axi_arvalid && s.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid  = 1'b1;
      s_nxt.rdata   = rdMux;
      s_nxt.rresp   = rdResp;
    end
    if (s.rvalid && s_axi_rready) begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s            <= '0;
      s.fsm        <= FBW_IDLE;
      s.blkSel     <= RST_BLK_SEL;
      s.bank       <= RST_BANK;
      s.redirEn    <= RST_REDIR;
      s.scratchEn  <= RST_SCRATCH;
      s.wrEraseEn  <= RST_WRERASE;
      s.bufData    <= {LANES{ERASED_BYTE}};
      s.pgmData    <= {LANES{ERASED_BYTE}};
      s.moveReady  <= 1'b1;
      s.awready    <= 1'b1;
      s.wready     <= 1'b1;
      s.arready    <= 1'b1;
    end else if (ce) begin
      s <= s_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready   = s.awready;
  assign s_axi_wready    = s.wready;
  assign s_axi_bresp     = s.bresp;
  assign s_axi_bvalid    = s.bvalid;
  assign s_axi_arready   = s.arready;
  assign s_axi_rdata     = s.rdata;
  assign s_axi_rresp     = s.rresp;
  assign s_axi_rvalid    = s.rvalid;
  assign moveWrReady     = s.moveReady;
  assign flashPgmStart   = s.pgmStart;
  assign flashPgmAddr    = s.pgmAddr;
  assign flashPgmData    = s.pgmData;
  assign flashPgmByteEn  = s.pgmByteEn;
  assign flashPgmBank    = s.pgmBank;
  assign flashPgmScratch = s.pgmScratch;
  assign extRamWrEn      = s.extRamWrEn;
  assign extRamWrAddr    = s.extRamWrAddr;
  assign extRamWrData    = s.extRamWrData;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_single_byte_start: assert property ( // RULE1
    ce && moveTake && s.redirEn && s.wrEraseEn && !s.blkSel
    |=> flashPgmStart && flashPgmAddr == $past(moveWrAddr)
        && !moveWrReady)
    else $error("single byte write did not start programming");

  a_block_hold_back: assert property ( // RULE4
    ce && moveTake && s.redirEn && s.wrEraseEn && s.blkSel && !lastByte
    |=> !flashPgmStart && moveWrReady)
    else $error("block programming started before last byte");

  a_code_block_go: assert property ( // RULE6
    ce && moveTake && s.redirEn && s.wrEraseEn && s.blkSel && !s.scratchEn
    && moveWrAddr[1:0] == 2'b11
    |=> flashPgmStart && flashPgmByteEn == 4'hF
        && flashPgmAddr[1:0] == 2'b00)
    else $error("code block not programmed after 11b byte");

  a_scratch_block_go: assert property ( // RULE7
    ce && moveTake && s.redirEn && s.wrEraseEn && s.blkSel && s.scratchEn
    && moveWrAddr[0]
    |=> flashPgmStart && flashPgmScratch && flashPgmAddr[0] == 1'b0)
    else $error("scratch block not programmed after 1b byte");

  a_prog_time_end: assert property ( // RULE3
    ce && s.fsm == FBW_PROG && s.timer == TMR_LAST
    |=> s.fsm == FBW_IDLE && moveWrReady)
    else $error("programming time not ended at its count");

  a_prog_time_start: assert property ( // RULE3
    flashPgmStart |-> s.timer == '0 && s.fsm == FBW_PROG)
    else $error("programming timer not restarted");

  a_no_pgm_disabled: assert property ( // RULE15
    ce && moveTake && !(s.redirEn && s.wrEraseEn) |=> !flashPgmStart)
    else $error("programming started with an enable clear");

  a_ram_redirect: assert property ( // RULE10
    ce && moveTake && !s.redirEn
    |=> extRamWrEn && extRamWrAddr == $past(moveWrAddr)
        && extRamWrData == $past(moveWrData))
    else $error("move write not steered to data RAM");

  a_bank_follows: assert property ( // RULE12
    ce && moveTake && s.redirEn && s.wrEraseEn
    |=> flashPgmBank == $past(s.bank)
        && flashPgmScratch == $past(s.scratchEn))
    else $error("bank or scratch target not taken from control");

  a_blk_readback: assert property ( // RULE14
    ce && s_axi_arvalid && s_axi_arready
    && s_axi_araddr == OFS_CACHE_CTRL
    |=> s_axi_rvalid && s_axi_rdata[BIT_BLK_SEL] == $past(s.blkSel))
    else $error("block select read back wrong");

  c_single_prog: cover property (
    ce && moveTake && s.redirEn && s.wrEraseEn && !s.blkSel);
  c_code_block: cover property (
    ce && moveTake && s.blkSel && !s.scratchEn && s.wrEraseEn
    && s.redirEn && lastByte && s.bufMask == 4'h7);
  c_scratch_block: cover property (
    ce && moveTake && s.blkSel && s.scratchEn && s.wrEraseEn
    && s.redirEn && lastByte);
  c_ram_write: cover property (ce && moveTake && !s.redirEn);

endmodule

// file: tb/fbw_core_model.sv
`timescale 1ns/1ps
module fbw_core_model
  import fbw_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  // Move write port
  input  wire logic              moveWrReady,
  output logic                   moveWrValid,
  output logic [ADDR_W-1:0]      moveWrAddr,
  output logic [7:0]             moveWrData
);
  initial begin
    moveWrValid = 1'b0;
    moveWrAddr  = 16'h0000;
    moveWrData  = 8'h00;
  end

  // Gap models a core that is slow to issue
  task automatic moveWrite(input logic [ADDR_W-1:0] a,
                           input logic [7:0] d, input int gap);
    repeat (gap + 1) @(posedge clk_sys);
    while (resetn !== 1'b1) @(posedge clk_sys);
    moveWrValid <= 1'b1;
    moveWrAddr  <= a;
    moveWrData  <= d;
    do @(posedge clk_sys); while (moveWrReady !== 1'b1);
    moveWrValid <= 1'b0;
    // Released lines show the inverse, so stale values cannot pass
    moveWrAddr  <= ~a;
    moveWrData  <= ~d;
  endtask
endmodule

// file: tb/tb_flash_byte_block_writer.sv
`timescale 1ns/1ps
module tb_flash_byte_block_writer
  import fbw_pkg::*;
;
  logic              clk_sys, resetn;
  logic [7:0]        s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_rready;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, bank;
  logic              moveWrValid, moveWrReady, flashPgmStart;
  logic [15:0]       moveWrAddr, flashPgmAddr, extRamWrAddr, a;
  logic [7:0]        moveWrData, extRamWrData, d;
  logic [31:0]       flashPgmData, v, ed;
  logic [3:0]        flashPgmByteEn, s_axi_wstrb;
  logic [1:0]        flashPgmBank, r;
  logic              flashPgmScratch, extRamWrEn;
  int                n_errors, compares, nPgm, nExtRam, busy, busy1, cyc, p;
  logic [7:0]        ofs [4];
  logic [31:0]       msk [4];

  // ****
  // Design and core
  // ****
  fbw_flash_block_writer #(.PGM_CYC(8)) dut_u (
    .clk_sys, .resetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .moveWrValid, .moveWrAddr, .moveWrData, .moveWrReady,
    .flashPgmStart, .flashPgmAddr, .flashPgmData, .flashPgmByteEn,
    .flashPgmBank, .flashPgmScratch, .extRamWrEn, .extRamWrAddr,
    .extRamWrData);

  fbw_core_model core_u (.clk_sys, .resetn, .moveWrReady, .moveWrValid,
    .moveWrAddr, .moveWrData);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Pulse counters and busy length of the last program
  always @(posedge clk_sys) begin
    cyc++;
    if (flashPgmStart === 1'b1) begin
      nPgm++;
      busy = 0;
    end else if (moveWrReady === 1'b0) begin
      busy++;
    end
    if (extRamWrEn === 1'b1) nExtRam++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  // ****
  // Tasks
  // ****
  task automatic print_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  // Expected data lanes of a single-byte program
  function automatic logic [31:0] laneMask(input logic [1:0] ln);
    return 32'h0000_00FF << (8 * ln);
  endfunction

  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clk_sys);
    s_axi_awaddr  <= ad;
    s_axi_wdata   <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad);
    @(posedge clk_sys);
    s_axi_araddr  <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wrOk(input logic [7:0] ad, input logic [31:0] dt);
    wr(ad, dt);
    cmp("bresp", 32'(RESP_OKAY), 32'(r));
  endtask

  task automatic mv(input logic [15:0] ma, input logic [7:0] md);
    p = nPgm;
    core_u.moveWrite(ma, md, $urandom_range(2));
    repeat (2) @(posedge clk_sys);
    while (moveWrReady !== 1'b1) @(posedge clk_sys);
  endtask

  task automatic chkPgm(input logic [15:0] ea, input logic [3:0] en,
                        input logic [31:0] m, input logic sc);
    cmp("pgmCount", 32'(p + 1), 32'(nPgm));
    cmp("pgmAddr", 32'(ea), 32'(flashPgmAddr));
    cmp("pgmEn", 32'(en), 32'(flashPgmByteEn));
    cmp("pgmData", ed & m, flashPgmData & m);
    cmp("pgmBank", 32'(bank), 32'(flashPgmBank));
    cmp("pgmScratch", 32'(sc), 32'(flashPgmScratch));
  endtask

  // ****
  // Sequence
  // ****
  initial begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    s_axi_wstrb = 4'hF;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    ofs = '{OFS_CACHE_CTRL, OFS_BANK, OFS_PS_CTRL, OFS_FLASH_SCALE};
    msk = '{32'h0000_0001, 32'h0000_0030, 32'h0000_0005, 32'h0000_0001};
    void'($urandom(93489));
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(ofs[i]);
      cmp("resetVal", 32'h0000_0000, v);
    end
    rd(8'h14);
    cmp("rresp", 32'(RESP_SLVERR), 32'(r));
    cmp("rdata", 32'h0000_0000, v);
    wr(8'h14, 32'hFFFF_FFFF);
    cmp("bresp", 32'(RESP_SLVERR), 32'(r));
    for (int i = 0; i < 4; i++) begin
      ed = $urandom;
      wrOk(ofs[i], ed);
      rd(ofs[i]);
      cmp("regRw", ed & msk[i], v);
    end
    wrOk(OFS_CACHE_CTRL, 32'h0000_0000);
    wrOk(OFS_FLASH_SCALE, 32'h0000_0000);
    wrOk(OFS_PS_CTRL, 32'h0000_0000);
    // Only byte lane 0 of the strobe writes the control bits
    s_axi_wstrb <= 4'hE;
    wrOk(OFS_CACHE_CTRL, 32'h0000_0001);
    s_axi_wstrb <= 4'hF;
    rd(OFS_CACHE_CTRL);
    cmp("strbLane0", 32'h0000_0000, v);
    // Redirect clear: moves land in data RAM
    a = $urandom;
    d = $urandom;
    mv(a, d);
    cmp("ramCount", 32'(1), 32'(nExtRam));
    cmp("ramAddr", 32'(a), 32'(extRamWrAddr));
    cmp("ramData", 32'(d), 32'(extRamWrData));
    wrOk(OFS_PS_CTRL, 32'h0000_0001);
    mv(a, d);
    cmp("noPgm", 32'(p), 32'(nPgm));
    cmp("noRam", 32'(1), 32'(nExtRam));
    wrOk(OFS_FLASH_SCALE, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      bank = $urandom;
      wrOk(OFS_BANK, 32'(bank) << BANK_LSB);
      a = (i == 0) ? 16'hFFFF : 16'($urandom);
      d = $urandom;
      ed = 32'(d) << (8 * a[1:0]);
      mv(a, d);
      chkPgm(a, 4'h1 << a[1:0], laneMask(a[1:0]), 1'b0);
      busy1 = busy;
    end
    // Code block, bytes in ascending order, one kept as erased
    wrOk(OFS_CACHE_CTRL, 32'h0000_0001);
    a = 16'($urandom) & 16'hFFFC;
    for (int k = 0; k < 4; k++) begin
      d = (k == 1) ? ERASED_BYTE : 8'($urandom);
      ed[8*k +: 8] = d;
      mv(a | 16'(k), d);
      if (k < 3) cmp("heldBack", 32'(p), 32'(nPgm));
    end
    chkPgm(a, 4'hF, 32'hFFFF_FFFF, 1'b0);
    cmp("blockBusy", 32'(busy1), 32'(busy));
    // Scratchpad pair
    wrOk(OFS_PS_CTRL, 32'h0000_0005);
    a = 16'($urandom) & 16'hFFFE;
    ed = 32'hFFFF_FFFF;
    for (int k = 0; k < 2; k++) begin
      d = $urandom;
      ed[8*(a[1:0]+k) +: 8] = d;
      mv(a | 16'(k), d);
      if (k == 0) cmp("heldBack", 32'(p), 32'(nPgm));
    end
    chkPgm(a, a[1] ? 4'hC : 4'h3, 32'hFFFF_FFFF, 1'b1);
    cmp("pairBusy", 32'(busy1), 32'(busy));
    // Four singles, one code block, one pair; idle, nothing pending
    rd(OFS_STATUS);
    cmp("status", 32'h0006_0000, v);
    // Closing order: redirect, then enable, then scratchpad
    wrOk(OFS_PS_CTRL, 32'h0000_0004);
    wrOk(OFS_FLASH_SCALE, 32'h0000_0000);
    wrOk(OFS_PS_CTRL, 32'h0000_0000);
    mv(16'h1234, 8'h5A);
    cmp("ramBack", 32'(2), 32'(nExtRam));
    cmp("ramBackAddr", 32'h0000_1234, 32'(extRamWrAddr));
    print_verdict();
  end
endmodule
